/* File: src/rgw_gateway_port.sv */
`timescale 1ns/1ns

module rgw_fifo
    import rgw_pkg::*;
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic      [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    // refused at elaboration: the pointer wrap bit only works for a power of two
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire              empty = (wr_ptr == rd_ptr);
    wire              push  = i_ce && i_valid && !full;
    wire              pop   = i_ce && i_ready && !empty;

    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge i_clk) begin
        if (push) mem[wr_ptr[AW-1:0]] <= i_data;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule : rgw_fifo

module rgw_gateway_port
    import rgw_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_ce,
    input  wire logic [2:0] i_mode_sel,
    input  wire logic       i_rate_slow,
    input  wire logic       i_no_handshake,
    input  wire logic       i_external_input_one,
    input  wire logic       i_cmd_valid,
    output logic            o_cmd_ready,
    input  wire rgw_byte_t  i_cmd,
    output logic            o_txd,
    input  wire logic       i_rxd,
    output logic            o_rx_valid,
    output rgw_byte_t       o_rx,
    output logic            o_rx_overflow,
    output logic            o_handshake_mode,
    output logic [7:0]      o_ctrl_bits
);
    // ---------------- mode and rate selection
    wire         mode_locked = (i_mode_sel == MODE_GW_HS);
    wire  [11:0] bit_div     = (mode_locked || !i_rate_slow) ? DIV_FAST : DIV_SLOW;
    wire         hs_mode     = mode_locked || !i_no_handshake;
    wire  [11:0] len_limit   = hs_mode ? MAX_LEN_HS : MAX_LEN_NOHS;
    assign o_handshake_mode = hs_mode;

    // ---------------- control bits: the input is only reported, nothing acts on it
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) o_ctrl_bits <= CTRL_RESET;
        else if (i_ce) begin
            o_ctrl_bits               <= CTRL_RESET;
            o_ctrl_bits[CTRL_READY]   <= 1'b1;
            o_ctrl_bits[CTRL_EXT_IN1] <= i_external_input_one;
        end
    end

    // ---------------- command buffer
    rgw_byte_t q_cmd;
    logic      q_valid;
    logic      q_pop;
    rgw_fifo #(.WIDTH($bits(rgw_byte_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_valid (i_cmd_valid),
        .o_ready (o_cmd_ready),
        .i_data  (i_cmd),
        .o_valid (q_valid),
        .i_ready (q_pop),
        .o_data  (q_cmd)
    );

    // ---------------- transmit framer
    rgw_txf_t    txf;
    rgw_txf_t    next_txf;
    logic [9:0]  tx_shift;
    logic [3:0]  tx_bits;
    logic [11:0] tx_cnt;
    wire         tx_free  = (tx_bits == 4'h0);
    wire         ld_stx   = tx_free && txf == TXF_IDLE && q_valid;
    wire         ld_data  = tx_free && txf == TXF_BODY && q_valid;
    wire         ld_etx   = tx_free && txf == TXF_END;
    wire         tx_load  = i_ce && (ld_stx || ld_data || ld_etx);
    wire  [7:0]  tx_byte  = ld_stx ? CHAR_STX : (ld_etx ? CHAR_ETX : q_cmd.data);
    assign q_pop    = ld_data;
    assign next_txf = ld_stx ? TXF_BODY :
                      (ld_data && q_cmd.last) ? TXF_END :
                      ld_etx ? TXF_IDLE : txf;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            txf      <= TXF_IDLE;
            tx_shift <= '1;
            tx_bits  <= 4'h0;
            tx_cnt   <= 12'h000;
        end else if (i_ce) begin
            txf <= next_txf;
            if (tx_load) begin
                tx_shift <= {1'b1, tx_byte, 1'b0};
                tx_bits  <= 4'ha;
                tx_cnt   <= bit_div - 12'h001;
            end else if (!tx_free) begin
                if (tx_cnt == 12'h000) begin
                    tx_shift <= {1'b1, tx_shift[9:1]};
                    tx_bits  <= tx_bits - 4'h1;
                    tx_cnt   <= bit_div - 12'h001;
                end else tx_cnt <= tx_cnt - 12'h001;
            end
        end
    end
    assign o_txd = tx_shift[0];

    // ---------------- receiver
    rgw_rxs_t    rxs;
    logic        rxd_q;
    logic [11:0] rx_cnt;
    logic [2:0]  rx_idx;
    logic [7:0]  rx_sh;
    logic        rx_in_frame;
    logic [11:0] rx_len;
    wire         rx_tick   = (rx_cnt == 12'h000);
    wire         rx_char   = i_ce && rxs == RXS_STOP && rx_tick && rxd_q;
    wire         is_stx    = rx_sh == CHAR_STX;
    wire         is_etx    = rx_sh == CHAR_ETX;
    wire         rx_full   = rx_len >= len_limit;
    wire         rx_keep   = rx_char && rx_in_frame && !is_stx;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rxs    <= RXS_IDLE;
            rxd_q  <= 1'b1;
            rx_cnt <= 12'h000;
            rx_idx <= 3'h0;
            rx_sh  <= 8'h00;
        end else if (i_ce) begin
            rxd_q  <= i_rxd;
            rx_cnt <= rx_tick ? bit_div - 12'h001 : rx_cnt - 12'h001;
            unique case (rxs)
                RXS_IDLE: if (!rxd_q) begin
                    rxs    <= RXS_START;
                    rx_cnt <= {1'b0, bit_div[11:1]};      // aim at mid bit
                end
                RXS_START: if (rx_tick) rxs <= rxd_q ? RXS_IDLE : RXS_BITS;
                RXS_BITS: if (rx_tick) begin
                    rx_sh  <= {rxd_q, rx_sh[7:1]};
                    rx_idx <= rx_idx + 3'h1;
                    if (rx_idx == 3'(DATA_BITS - 1)) rxs <= RXS_STOP;
                end
                RXS_STOP: if (rx_tick) rxs <= RXS_IDLE;  // low stop bit drops the char
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_in_frame   <= 1'b0;
            rx_len        <= 12'h000;
            o_rx_valid    <= 1'b0;
            o_rx          <= '0;
            o_rx_overflow <= 1'b0;
        end else if (i_ce) begin
            o_rx_valid    <= rx_keep && (is_etx || !rx_full);
            o_rx_overflow <= rx_keep && !is_etx && rx_full;
            if (rx_char && is_stx) begin
                rx_in_frame <= 1'b1;
                rx_len      <= 12'h000;
            end else if (rx_keep) begin
                // the end marker closes the string and is passed as a flagged empty byte
                o_rx <= '{last: is_etx, data: is_etx ? 8'h00 : rx_sh};
                if (is_etx || rx_full) rx_in_frame <= 1'b0;
                else rx_len <= rx_len + 12'h001;
            end
        end
    end

    // ---------------- checks
    a_start_low: assert property (@(posedge i_clk) disable iff (i_rst)
        tx_load |=> !o_txd) else $error("start bit not low");
    a_stx_leads: assert property (@(posedge i_clk) disable iff (i_rst)
        (tx_load && txf == TXF_IDLE) |-> tx_byte == CHAR_STX)
        else $error("frame not opened by start char");
    a_etx_closes: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && ld_data && q_cmd.last) |=> txf == TXF_END)
        else $error("end char not scheduled");
    a_rate_lock: assert property (@(posedge i_clk) disable iff (i_rst)
        mode_locked |-> bit_div == DIV_FAST && o_handshake_mode)
        else $error("mode 2 not locked");
    a_stop_high: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && !tx_free && tx_bits == 4'h1) |-> o_txd)
        else $error("stop bit not high");
    a_spare_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        o_ctrl_bits[7:2] == 6'h00) else $error("spare control bit set");
    a_ext_report: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce |=> o_ctrl_bits[CTRL_EXT_IN1] == $past(i_external_input_one))
        else $error("input one not reported");
    a_len_bound: assert property (@(posedge i_clk) disable iff (i_rst)
        o_rx_valid && !o_rx.last |-> rx_len <= len_limit)
        else $error("string longer than limit");
    c_frame_sent: cover property (@(posedge i_clk) disable iff (i_rst) i_ce && ld_etx);
    c_frame_rcvd: cover property (@(posedge i_clk) disable iff (i_rst) o_rx_valid && o_rx.last);
    c_overflow:   cover property (@(posedge i_clk) disable iff (i_rst) o_rx_overflow);
endmodule : rgw_gateway_port

/* File: src/rgw_pkg.sv */
package rgw_pkg;
    localparam int          CLK_HZ        = 25_000_000;
    localparam int          BAUD_FAST     = 57_600;
    localparam int          BAUD_SLOW     = 9_600;
    // nearest whole divisor; the error stays well under one percent
    localparam logic [11:0] DIV_FAST      = 12'((CLK_HZ + BAUD_FAST / 2) / BAUD_FAST);
    localparam logic [11:0] DIV_SLOW      = 12'((CLK_HZ + BAUD_SLOW / 2) / BAUD_SLOW);
    localparam int          DATA_BITS     = 8;
    localparam logic [7:0]  CHAR_STX      = 8'h02;
    localparam logic [7:0]  CHAR_ETX      = 8'h03;
    localparam logic [2:0]  MODE_GW_HS    = 3'h2;
    localparam logic [11:0] MAX_LEN_HS    = 12'(4000);
    localparam logic [11:0] MAX_LEN_NOHS  = 12'(123);
    localparam int          CTRL_READY    = 0;
    localparam int          CTRL_EXT_IN1  = 1;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam int          FIFO_DEPTH    = 16;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } rgw_byte_t;

    typedef enum logic [1:0] {TXF_IDLE, TXF_BODY, TXF_END} rgw_txf_t;
    typedef enum logic [1:0] {RXS_IDLE, RXS_START, RXS_BITS, RXS_STOP} rgw_rxs_t;
endpackage : rgw_pkg

/* File: bench/rgw_serial_dev.sv */
`timescale 1ns/1ns

module rgw_serial_dev
    import rgw_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_txd,
    output logic      o_rxd
);
    int         div = int'(DIV_FAST);
    logic [7:0] got[$];
    logic [7:0] sh;

    // the far line rests at mark between characters
    initial o_rxd = 1'b1;
    always begin
        @(negedge i_txd);
        repeat (div / 2) @(posedge i_clk);
        for (int k = 0; k < 8; k++) begin
            repeat (div) @(posedge i_clk);
            sh[k] = i_txd;
        end
        repeat (div) @(posedge i_clk);
        if (i_txd === 1'b1) got.push_back(sh);
    end

    task automatic send_char(input logic [7:0] c);
        logic [9:0] fr;
        fr = {1'b1, c, 1'b0};
        for (int k = 0; k < 10; k++) begin
            @(negedge i_clk);
            o_rxd = fr[k];
            repeat (div - 1) @(negedge i_clk);
        end
    endtask : send_char

    task automatic send_str(input logic [7:0] s[$]);
        send_char(8'h02);
        foreach (s[k]) send_char(s[k]);
        send_char(8'h03);
    endtask : send_str
endmodule : rgw_serial_dev

/* File: bench/rgw_gateway_port_tb_top.sv */
`timescale 1ns/1ns

module rgw_gateway_port_tb_top
    import rgw_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] mode = 3'h0;
    logic       slow = 1'b0, nohs = 1'b0, ext = 1'b0, cv = 1'b0;
    logic       ce = 1'b1;
    rgw_byte_t  cmd = '0;
    logic       cr, txd, rxd, rv, ovf, hs;
    rgw_byte_t  rx, rxq[$];
    logic [7:0] ctrl;
    int         err_count = 0, cmp_count = 0, cyc = 0, ovf_n = 0;

    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rv === 1'b1) rxq.push_back(rx);
        if (ovf === 1'b1) ovf_n <= ovf_n + 1;
        if (cyc == 90000) begin
            err_count++;
            complete_run();
        end
    end

    rgw_gateway_port uut (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_mode_sel(mode),
        .i_rate_slow(slow), .i_no_handshake(nohs), .i_external_input_one(ext),
        .i_cmd_valid(cv), .o_cmd_ready(cr), .i_cmd(cmd), .o_txd(txd), .i_rxd(rxd),
        .o_rx_valid(rv), .o_rx(rx), .o_rx_overflow(ovf), .o_handshake_mode(hs),
        .o_ctrl_bits(ctrl));
    rgw_serial_dev dev (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));

    task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t ns: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic push(input logic [7:0] d, input logic l);
        @(negedge clk);
        cv = 1'b1;
        cmd = '{last: l, data: d};
        while (cr !== 1'b1) @(negedge clk);
        @(negedge clk);
        cv = 1'b0;
    endtask : push

    task automatic t_ctrl;
        check({8'h0, hs}, 9'h1, "handshake default");
        for (int k = 0; k < 2; k++) begin
            @(negedge clk);
            ext = k[0];
            repeat (3) @(negedge clk);
            check({1'b0, ctrl}, {7'h0, k[0], 1'b1}, "control bits");
        end
        // with the enable low the report must hold its last value
        @(negedge clk);
        ce  = 1'b0;
        ext = 1'b0;
        repeat (3) @(negedge clk);
        check({1'b0, ctrl}, 9'h003, "frozen by enable");
        ce = 1'b1;
        $display("test ctrl done");
    endtask : t_ctrl

    task automatic t_rx;
        logic [8:0] e[3] = '{9'h031, 9'h032, 9'h100};
        rxq.delete();
        dev.send_char(8'h41);
        dev.send_str('{8'h31, 8'h32});
        repeat (500) @(posedge clk);
        check(9'(rxq.size()), 9'd3, "rx count");
        for (int k = 0; k < 3; k++)
            check(rxq.size() > k ? rxq[k] : 9'h1ff, e[k], "rx entry");
        check(9'(ovf_n), 9'd0, "overflow pulses");
        $display("test rx done");
    endtask : t_rx

    task automatic t_tx;
        logic [7:0] e[4] = '{CHAR_STX, 8'ha5, 8'h3c, CHAR_ETX};
        dev.got.delete();
        push(8'ha5, 1'b0);
        push(8'h3c, 1'b1);
        repeat (40 * int'(DIV_FAST) + 1000) @(posedge clk);
        check(9'(dev.got.size()), 9'd4, "tx count");
        for (int k = 0; k < 4; k++)
            check(dev.got.size() > k ? dev.got[k] : 9'h1ff, {1'b0, e[k]}, "tx char");
        $display("test tx done");
    endtask : t_tx

    task automatic t_fifo;
        int n = 0;
        @(negedge clk);
        cv = 1'b1;
        cmd = '{last: 1'b0, data: 8'h55};
        while (cr === 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        repeat (4) @(negedge clk);
        cv = 1'b0;
        check(9'(n >= FIFO_DEPTH && n <= FIFO_DEPTH + 1), 9'd1, "fifo depth");
        check({8'h0, cr}, 9'h0, "fifo refuses");
        $display("test fifo done");
    endtask : t_fifo

    // stx is sent lsb first: start bit and bit0 make one low stretch of two bit times
    task automatic bit_width(input logic [2:0] m, input int exp);
        int w = 0;
        int n = 0;
        @(negedge clk);
        rst = 1'b1;
        mode = m;
        slow = 1'b1;
        nohs = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        check({8'h0, hs}, {8'h0, m == MODE_GW_HS}, "handshake mode");
        push(8'h00, 1'b1);
        // sampled on the falling edge, clear of the edge that launches each bit
        while (txd !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        while (txd === 1'b0 && w < 6000) begin
            @(negedge clk);
            w++;
        end
        check(9'(w >= exp - 1 && w <= exp + 1), 9'd1, "bit time");
        $display("test rate done");
    endtask : bit_width

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        t_ctrl();
        t_rx();
        t_tx();
        t_fifo();
        bit_width(3'h0, 2 * int'(DIV_SLOW));
        bit_width(MODE_GW_HS, 2 * int'(DIV_FAST));
        complete_run();
    end
endmodule : rgw_gateway_port_tb_top
